// [hdl/operating_mode_select.sv]
// operating-mode select: strap capture, port configuration, mode register
// assumes strap pins are asynchronous and software uses axi4-lite
module operating_mode_select (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        debug_strap_pin,
   input  wire logic        mode_select_b_pin,
   input  wire logic        mode_select_a_pin,
   input  wire logic        ext_req,
   input  wire logic [15:0] ext_wdata,
   input  wire logic [15:0] ext_addr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [7:0]  awaddr,
   input  wire logic        wvalid,
   output logic             wready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   output logic             bvalid,
   input  wire logic        bready,
   output logic [1:0]       bresp,
   input  wire logic        arvalid,
   output logic             arready,
   input  wire logic [7:0]  araddr,
   output logic             rvalid,
   input  wire logic        rready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             debug_pullup_en,
   output logic             mode_pulldown_en,
   output logic             bus_control_pullup_en,
   output logic             port_ab_pullup_en,
   output logic [7:0]       port_a_addr_data_en,
   output logic [7:0]       port_b_addr_data_en,
   output logic [7:0]       bus_control_func_en,
   output logic [1:0]       bus_control_input_only,
   output logic [7:0]       port_a_out,
   output logic [7:0]       port_b_out,
   output logic             ext_busy,
   output logic             cpu_run,
   output logic             vector_fetch_en,
   output logic             serial_debug_mode,
   output logic             port_ab_regs_mapped,
   output logic             bus_control_regs_mapped,
   output logic             protect_en
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [2:0]   dbg_sync;
      logic [2:0]   b_sync;
      logic [2:0]   a_sync;
      logic         in_reset;
      logic [2:0]   mode;
      logic         mode_written;
      logic         port_emul;
      logic         dbg_enabled;
      logic         dbg_active;
      opmode_pkg::xfer_t xf;
      logic [15:0]  xf_addr;
      logic [15:0]  xf_data;
      logic         aw_got;
      logic         w_got;
      logic [7:0]   aw_addr;
      logic [31:0]  w_data;
      logic         bvalid;
      logic [1:0]   bresp;
      logic         rvalid;
      logic [31:0]  rdata;
      logic [1:0]   rresp;
   } state_t;
   state_t st_ff;
   state_t nxt_st;

   function automatic logic is_single(input logic [2:0] m);
      return m[1:0] == 2'b00;
   endfunction : is_single
   function automatic logic is_narrow(input logic [2:0] m);
      return m[1:0] == 2'b01;
   endfunction : is_narrow
   function automatic logic is_wide(input logic [2:0] m);
      return m[1:0] == 2'b11;
   endfunction : is_wide
   function automatic logic is_periph(input logic [2:0] m);
      return m == opmode_pkg::SPC_PERIPH;
   endfunction : is_periph
   function automatic logic [2:0] decode(input logic [2:0] s);
      return (s == opmode_pkg::RESERVED) ? opmode_pkg::SPC_PERIPH : s;
   endfunction : decode

   logic [31:0] mode_word;
   logic        wr_fire;
   logic        rd_fire;
   logic [2:0]  strap_now;
   logic [2:0]  wr_mode;
   assign mode_word = {24'h0, st_ff.mode, 4'h0, st_ff.port_emul};
   assign wr_fire   = st_ff.aw_got && st_ff.w_got && !st_ff.bvalid;
   assign rd_fire   = arvalid && arready;
   // settled strap levels: second and third stages agree
   assign strap_now = {st_ff.dbg_sync[2], st_ff.b_sync[2], st_ff.a_sync[2]};
   assign wr_mode   = {st_ff.mode[2], st_ff.w_data[opmode_pkg::MODE_B_POS], st_ff.w_data[opmode_pkg::MODE_A_POS]};

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.dbg_sync = {st_ff.dbg_sync[1:0], debug_strap_pin};
      nxt_st.b_sync   = {st_ff.b_sync[1:0], mode_select_b_pin};
      nxt_st.a_sync   = {st_ff.a_sync[1:0], mode_select_a_pin};
      nxt_st.in_reset = 1'b0;
      // capture at the first edge after release at which the second and third sync stages agree
      if (st_ff.in_reset && st_ff.dbg_sync[2] == st_ff.dbg_sync[1] && st_ff.b_sync[2] == st_ff.b_sync[1]
          && st_ff.a_sync[2] == st_ff.a_sync[1]) begin
         nxt_st.mode = decode(strap_now);
         nxt_st.port_emul = !strap_now[2] && !is_single(decode(strap_now));
         nxt_st.dbg_active  = decode(strap_now) == opmode_pkg::SPC_SINGLE;
         nxt_st.dbg_enabled = decode(strap_now) == opmode_pkg::SPC_SINGLE;
      end else if (st_ff.in_reset) begin
         nxt_st.in_reset = 1'b1;
      end
      // write channel
      // taken only on the edge where valid meets ready, so a held valid is never taken twice
      if (awvalid && awready) begin
         nxt_st.aw_got  = 1'b1;
         nxt_st.aw_addr = awaddr;
      end
      if (wvalid && wready) begin
         nxt_st.w_got  = 1'b1;
         nxt_st.w_data = wdata;
      end
      if (wr_fire) begin
         nxt_st.aw_got = 1'b0;
         nxt_st.w_got  = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp  = opmode_pkg::RESP_OKAY;
         if (st_ff.aw_addr == opmode_pkg::MODE_OFS && !is_periph(st_ff.mode) && wstrb_ok(st_ff)) begin
            // no write reaches or leaves peripheral
            // decode folds the reserved code onto peripheral, so both are refused here
            if ((!st_ff.mode[2] || !st_ff.mode_written) && !is_periph(decode(wr_mode))) begin
               nxt_st.mode         = wr_mode;
               nxt_st.mode_written = 1'b1;
            end
            // emulation bit writable in normal modes only until a mode write is taken
            if (!st_ff.mode[2] || !st_ff.mode_written) begin
               nxt_st.port_emul = st_ff.w_data[opmode_pkg::EMUL_POS];
            end
         end else if (st_ff.aw_addr == opmode_pkg::DEBUG_OFS && !is_periph(st_ff.mode)) begin
            if (st_ff.w_data[0]) begin
               nxt_st.dbg_enabled = 1'b1;
            end
            if (st_ff.w_data[1] && st_ff.dbg_enabled) begin
               nxt_st.dbg_active = 1'b1;
            end
         end else if (st_ff.aw_addr != opmode_pkg::CONFIG_OFS) begin
            nxt_st.bresp = opmode_pkg::RESP_SLVERR;
         end
      end
      if (st_ff.bvalid && bready) begin
         nxt_st.bvalid = 1'b0;
      end
      if (rd_fire) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rresp  = opmode_pkg::RESP_OKAY;
         if (araddr == opmode_pkg::MODE_OFS) begin
            nxt_st.rdata = mode_word;
         end else if (araddr == opmode_pkg::CONFIG_OFS) begin
            nxt_st.rdata = {29'h0, port_map_ab(st_ff.mode), port_map_e(st_ff.mode, st_ff.port_emul), !st_ff.mode[2]};
         end else if (araddr == opmode_pkg::DEBUG_OFS) begin
            nxt_st.rdata = {30'h0, st_ff.dbg_active, st_ff.dbg_enabled};
         end else begin
            nxt_st.rdata = 32'h0;
            nxt_st.rresp = opmode_pkg::RESP_SLVERR;
         end
      end else if (st_ff.rvalid && rready) begin
         nxt_st.rvalid = 1'b0;
      end
      // narrow modes split each 16-bit transfer, high byte first
      case (st_ff.xf)
         opmode_pkg::XF_IDLE: begin
            if (ext_req && !is_single(st_ff.mode) && !st_ff.in_reset) begin
               nxt_st.xf_addr = ext_addr;
               nxt_st.xf_data = ext_wdata;
               nxt_st.xf = is_narrow(st_ff.mode) ? opmode_pkg::XF_HIGH : opmode_pkg::XF_LOW;
            end
         end
         opmode_pkg::XF_HIGH: begin
            nxt_st.xf = opmode_pkg::XF_LOW;
         end
         opmode_pkg::XF_LOW: begin
            nxt_st.xf = opmode_pkg::XF_IDLE;
         end
         default: begin
            nxt_st.xf = opmode_pkg::XF_IDLE;
         end
      endcase
      if (!aresetn) begin
         nxt_st = '0;
         nxt_st.dbg_sync = {st_ff.dbg_sync[1:0], debug_strap_pin};
         nxt_st.b_sync   = {st_ff.b_sync[1:0], mode_select_b_pin};
         nxt_st.a_sync   = {st_ff.a_sync[1:0], mode_select_a_pin};
         nxt_st.in_reset = 1'b1;
         nxt_st.mode     = opmode_pkg::OPEN_STRAP;
         nxt_st.xf       = opmode_pkg::XF_IDLE;
      end
   end

   function automatic logic wstrb_ok(input state_t s);
      return wstrb[0];
   endfunction : wstrb_ok
   // port a/b registers only in single-chip
   function automatic logic port_map_ab(input logic [2:0] m);
      return is_single(m);
   endfunction : port_map_ab
   function automatic logic port_map_e(input logic [2:0] m, input logic e);
      return is_single(m) || (!is_periph(m) && !e);
   endfunction : port_map_e

   always_ff @(posedge aclk) begin
      st_ff <= nxt_st;
   end

   // ---------------------------------------------------------------
   // registered outputs
   // ---------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         wready  <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= opmode_pkg::RESP_OKAY;
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0;
         rresp   <= opmode_pkg::RESP_OKAY;
         debug_pullup_en  <= 1'b1;
         mode_pulldown_en <= 1'b1;
         bus_control_pullup_en <= 1'b1;
         port_ab_pullup_en     <= 1'b0;
         port_a_addr_data_en   <= 8'h00;
         port_b_addr_data_en   <= 8'h00;
         bus_control_func_en   <= 8'h00;
         bus_control_input_only <= 2'h3;
         port_a_out <= 8'h00;
         port_b_out <= 8'h00;
         ext_busy   <= 1'b0;
         cpu_run    <= 1'b0;
         vector_fetch_en   <= 1'b0;
         serial_debug_mode <= 1'b0;
         port_ab_regs_mapped     <= 1'b1;
         bus_control_regs_mapped <= 1'b1;
         protect_en <= 1'b1;
      end else begin
         awready <= !nxt_st.aw_got;
         wready  <= !nxt_st.w_got;
         bvalid  <= nxt_st.bvalid;
         bresp   <= nxt_st.bresp;
         arready <= !nxt_st.rvalid;
         rvalid  <= nxt_st.rvalid;
         rdata   <= nxt_st.rdata;
         rresp   <= nxt_st.rresp;
         debug_pullup_en  <= nxt_st.in_reset;
         mode_pulldown_en <= nxt_st.in_reset;
         port_a_addr_data_en <= is_single(nxt_st.mode) ? 8'h00 : 8'hff;
         port_b_addr_data_en <= is_single(nxt_st.mode) ? 8'h00 : 8'hff;
         bus_control_func_en <= (nxt_st.mode == opmode_pkg::SPC_WIDE) ? 8'hff :
                                (is_single(nxt_st.mode) ? 8'h00 : 8'hfc);
         bus_control_input_only <= (nxt_st.mode == opmode_pkg::NRM_SINGLE) ? 2'h3 : 2'h0;
         // data phase only: narrow puts high then low data byte on port a, address low on port b
         port_a_out <= (nxt_st.xf == opmode_pkg::XF_HIGH || !is_narrow(st_ff.mode))
                       ? nxt_st.xf_data[15:8] : nxt_st.xf_data[7:0];
         port_b_out <= is_narrow(st_ff.mode) ? nxt_st.xf_addr[7:0] : nxt_st.xf_data[7:0];
         ext_busy   <= nxt_st.xf != opmode_pkg::XF_IDLE;
         cpu_run    <= !nxt_st.in_reset && !is_periph(nxt_st.mode) && !nxt_st.dbg_active;
         vector_fetch_en   <= !nxt_st.in_reset && nxt_st.mode != opmode_pkg::SPC_SINGLE;
         serial_debug_mode <= nxt_st.dbg_active && !is_periph(nxt_st.mode);
         port_ab_regs_mapped     <= port_map_ab(nxt_st.mode);
         bus_control_regs_mapped <= port_map_e(nxt_st.mode, nxt_st.port_emul);
         protect_en <= nxt_st.mode[2];
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_pull_in_reset;
      @(posedge aclk) !aresetn |=> debug_pullup_en && mode_pulldown_en;
   endproperty
   a_pull_in_reset: assert property (p_pull_in_reset) else $error("strap pulls off in reset");
   property p_no_periph_by_write;
      @(posedge aclk) disable iff (!aresetn) !st_ff.in_reset && !is_periph(st_ff.mode) |=> !is_periph(st_ff.mode);
   endproperty
   a_no_periph_by_write: assert property (p_no_periph_by_write) else $error("peripheral entered");
   property p_periph_stays;
      @(posedge aclk) disable iff (!aresetn) is_periph(st_ff.mode) && !st_ff.in_reset |=> is_periph(st_ff.mode);
   endproperty
   a_periph_stays: assert property (p_periph_stays) else $error("peripheral left");
   property p_never_reserved;
      @(posedge aclk) disable iff (!aresetn) st_ff.mode != opmode_pkg::RESERVED;
   endproperty
   a_never_reserved: assert property (p_never_reserved) else $error("reserved mode held");
   property p_narrow_two_cycles;
      @(posedge aclk) disable iff (!aresetn) st_ff.xf == opmode_pkg::XF_HIGH |=> st_ff.xf == opmode_pkg::XF_LOW;
   endproperty
   a_narrow_two_cycles: assert property (p_narrow_two_cycles) else $error("low byte missing");
   property p_single_gpio;
      @(posedge aclk) disable iff (!aresetn) is_single(st_ff.mode)
         |-> port_a_addr_data_en == 8'h00 && port_b_addr_data_en == 8'h00;
   endproperty
   a_single_gpio: assert property (p_single_gpio) else $error("bus in single-chip");
   property p_periph_cpu_off;
      @(posedge aclk) disable iff (!aresetn) is_periph(st_ff.mode) |=> !cpu_run;
   endproperty
   a_periph_cpu_off: assert property (p_periph_cpu_off) else $error("cpu runs in peripheral");
   property p_map_ab;
      @(posedge aclk) disable iff (!aresetn) !is_single(st_ff.mode) ##1 !is_single(st_ff.mode)
         |-> !port_ab_regs_mapped;
   endproperty
   a_map_ab: assert property (p_map_ab) else $error("port regs mapped");
   c_narrow: cover property (@(posedge aclk) st_ff.xf == opmode_pkg::XF_HIGH);
   c_debug: cover property (@(posedge aclk) serial_debug_mode);
   c_write: cover property (@(posedge aclk) wr_fire);
endmodule : operating_mode_select

// [hdl/opmode_pkg.sv]
// constants for the operating-mode select block
// assumes a single 100 MHz clock and an axi4-lite register master
package opmode_pkg;
   // ---------------------------------------------------------------
   // register offsets (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] MODE_OFS    = 8'h00;
   localparam logic [7:0] CONFIG_OFS  = 8'h04;
   localparam logic [7:0] DEBUG_OFS   = 8'h08;
   // ---------------------------------------------------------------
   // mode register fields
   // ---------------------------------------------------------------
   localparam int SPECIAL_N_POS = 7;
   localparam int MODE_B_POS    = 6;
   localparam int MODE_A_POS    = 5;
   localparam int EMUL_POS      = 0;
   // ---------------------------------------------------------------
   // mode codes {debug, b, a}
   // ---------------------------------------------------------------
   localparam logic [2:0] SPC_SINGLE = 3'h0;
   localparam logic [2:0] SPC_NARROW = 3'h1;
   localparam logic [2:0] SPC_PERIPH = 3'h2;
   localparam logic [2:0] SPC_WIDE   = 3'h3;
   localparam logic [2:0] NRM_SINGLE = 3'h4;
   localparam logic [2:0] NRM_NARROW = 3'h5;
   localparam logic [2:0] RESERVED   = 3'h6;
   localparam logic [2:0] NRM_WIDE   = 3'h7;
   localparam logic [2:0] OPEN_STRAP = 3'h4;
   localparam logic [1:0] RESP_OKAY  = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [2:0] {
      XF_IDLE = 3'b001,
      XF_HIGH = 3'b010,
      XF_LOW  = 3'b100
   } xfer_t;
endpackage : opmode_pkg

// [testbench/ext_side_model.sv]
// far side of the block: strap jumpers on the three mode pins, and a
// recorder of the external memory bus. assumes the single aclk domain.
module ext_side_model (
   input  wire logic       aclk,
   input  wire logic [2:0] strap_drv,
   input  wire logic [2:0] strap_open,
   input  wire logic       debug_pullup_en,
   input  wire logic       mode_pulldown_en,
   input  wire logic       ext_busy,
   input  wire logic [7:0] port_a_out,
   input  wire logic [7:0] port_b_out,
   output logic [2:0]      strap_pins
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0]  last_ff;
   logic [15:0] seen[$];
   // -------------------------------------------------------------
   // strap resolution
   // -------------------------------------------------------------
   // an open pin with no pull active floats: show the inverse of the last level
   always_comb begin
      strap_pins[2] = strap_open[2] ? (debug_pullup_en ? 1'b1 : ~last_ff[2]) : strap_drv[2];
      strap_pins[1] = strap_open[1] ? (mode_pulldown_en ? 1'b0 : ~last_ff[1]) : strap_drv[1];
      strap_pins[0] = strap_open[0] ? (mode_pulldown_en ? 1'b0 : ~last_ff[0]) : strap_drv[0];
   end
   always_ff @(posedge aclk) last_ff <= strap_pins;
   // -------------------------------------------------------------
   // bus recorder
   // -------------------------------------------------------------
   always @(posedge aclk) if (ext_busy) seen.push_back({port_a_out, port_b_out});
endmodule : ext_side_model

// [testbench/tb.sv]
// self-checking bench for the operating-mode select block
// assumes a 100 MHz aclk and an axi4-lite register port
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 0, aresetn = 0, ext_req = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [15:0] ext_wdata = 16'h0000, ext_addr = 16'h0000;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rd, lfsr_ff = 32'h21dfbe11;
   logic [2:0]  strap_drv = 3'h0, strap_open = 3'h0, pins;
   logic awready, wready, bvalid, arready, rvalid, debug_pullup_en, mode_pulldown_en, bus_control_pullup_en;
   logic port_ab_pullup_en, ext_busy, cpu_run, vector_fetch_en, serial_debug_mode, port_ab_regs_mapped;
   logic bus_control_regs_mapped, protect_en;
   logic [1:0]  bresp, rresp, bus_control_input_only, rs;
   logic [31:0] rdata;
   logic [7:0]  port_a_addr_data_en, port_b_addr_data_en, bus_control_func_en, port_a_out, port_b_out;
   int bad_count = 0, samples_checked = 0;

   operating_mode_select operating_mode_select_inst (.aclk, .aresetn, .debug_strap_pin(pins[2]),
      .mode_select_b_pin(pins[1]), .mode_select_a_pin(pins[0]), .ext_req, .ext_wdata, .ext_addr,
      .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp,
      .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp, .debug_pullup_en, .mode_pulldown_en,
      .bus_control_pullup_en, .port_ab_pullup_en, .port_a_addr_data_en, .port_b_addr_data_en,
      .bus_control_func_en, .bus_control_input_only, .port_a_out, .port_b_out, .ext_busy, .cpu_run,
      .vector_fetch_en, .serial_debug_mode, .port_ab_regs_mapped, .bus_control_regs_mapped, .protect_en);
   ext_side_model ext_side_model_inst (.aclk, .strap_drv, .strap_open, .debug_pullup_en, .mode_pulldown_en,
      .ext_busy, .port_a_out, .port_b_out, .strap_pins(pins));

   always #5 aclk = ~aclk;
   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return (s >> 1) ^ (s[0] ? 32'h80200003 : 32'h0);
   endfunction : lfsr_next
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test
   // every bus task starts and ends just after a rising edge
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = opmode_pkg::RESP_OKAY);
      bit done;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         done = bvalid;
         if (bvalid) rs = bresp;
      end
      bready <= 1'b0;
      chk("bresp", 32'(er), 32'(rs));
      @(posedge aclk);
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a);
      bit done;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         done = rvalid;
         rd = rdata;
         rs = rresp;
      end
      arvalid <= 1'b0;
      rready <= 1'b0;
      chk("rvalid", 1, 32'(done));
      @(posedge aclk);
   endtask : axi_rd
   task automatic mode_is(input logic [2:0] e);
      axi_rd(opmode_pkg::MODE_OFS);
      chk("mode_bits", 32'(e), 32'(rd[7:5]));
   endtask : mode_is
   task automatic do_reset(input logic [2:0] drv, input logic [2:0] op);
      aresetn <= 1'b0;
      strap_drv <= drv;
      strap_open <= op;
      repeat (10) @(posedge aclk);
      chk("debug_pullup_en", 1, 32'(debug_pullup_en));
      chk("mode_pulldown_en", 1, 32'(mode_pulldown_en));
      chk("bus_control_pullup_en", 1, 32'(bus_control_pullup_en));
      chk("port_ab_pullup_en", 0, 32'(port_ab_pullup_en));
      aresetn <= 1'b1;
      repeat (8) @(posedge aclk);
      // pins move after capture; the latched mode must not follow
      strap_drv <= ~drv;
      repeat (4) @(posedge aclk);
   endtask : do_reset
   // -------------------------------------------------------------
   // reference model of the strap decode
   // -------------------------------------------------------------
   task automatic check_mode(input logic [2:0] code);
      logic [2:0] m;
      bit single, periph;
      m = (code == 3'h6) ? 3'h2 : code;
      single = (m[1:0] == 2'b00);
      periph = (m == 3'h2);
      mode_is(m);
      chk("port_a_addr_data_en", single ? 0 : 32'hff, 32'(port_a_addr_data_en));
      chk("port_b_addr_data_en", single ? 0 : 32'hff, 32'(port_b_addr_data_en));
      chk("bus_control_func_en", m == 3 ? 32'hff : single ? 0 : 32'hfc, 32'(bus_control_func_en));
      chk("bus_control_input_only", m == 4 ? 3 : 0, 32'(bus_control_input_only));
      chk("port_ab_regs_mapped", 32'(single), 32'(port_ab_regs_mapped));
      if (single || periph) chk("bus_control_regs_mapped", 32'(single), 32'(bus_control_regs_mapped));
      chk("protect_en", 32'(m[2]), 32'(protect_en));
      chk("cpu_run", 32'(!periph && m != 0), 32'(cpu_run));
      chk("vector_fetch_en", 32'(m != 0), 32'(vector_fetch_en));
      if (m == 0) chk("serial_debug_mode", 1, 32'(serial_debug_mode));
      if (m[2]) chk("serial_debug_mode", 0, 32'(serial_debug_mode));
   endtask : check_mode
   task automatic ext_xfer(input logic [2:0] m);
      int hi = -1, lo = -1, w = -1;
      ext_side_model_inst.seen.delete();
      do lfsr_ff = lfsr_next(lfsr_ff);
      while (lfsr_ff[15:8] == lfsr_ff[7:0]);
      ext_wdata <= lfsr_ff[15:0];
      ext_addr <= lfsr_ff[31:16];
      ext_req <= 1'b1;
      @(posedge aclk);
      ext_req <= 1'b0;
      for (int n = 0; n < 30; n++) begin
         @(posedge aclk);
         if (ext_side_model_inst.seen.size() > 0 && !ext_busy) break;
      end
      foreach (ext_side_model_inst.seen[i]) begin
         if (ext_side_model_inst.seen[i][15:8] === lfsr_ff[15:8] && hi < 0) hi = i;
         if (ext_side_model_inst.seen[i][15:8] === lfsr_ff[7:0]) lo = i;
         if (ext_side_model_inst.seen[i] === lfsr_ff[15:0]) w = i;
      end
      if (m[1:0] == 0) chk("ext_cycles", 0, 32'(ext_side_model_inst.seen.size()));
      if (m[1:0] == 3) chk("wide_word", 1, 32'(w >= 0));
      if (m[1:0] == 1) chk("high_then_low", 1, 32'(hi >= 0 && lo > hi));
      if (m[1:0] == 1) chk("narrow_addr_lo", 32'(lfsr_ff[23:16]), hi >= 0 ? 32'(ext_side_model_inst.seen[hi][7:0]) : 32'hdead);
   endtask : ext_xfer
   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial begin
      for (int c = 0; c < 8; c++) begin
         do_reset(3'(c), 3'h0);
         check_mode(3'(c));
         if (c == 4 || c == 5 || c == 7) ext_xfer(3'(c));
         $display("test strap code %0d done", c);
      end
      do_reset(3'h0, 3'h7);
      check_mode(3'h4);
      $display("test open straps done");
      do_reset(3'h5, 3'h0);
      axi_wr(opmode_pkg::MODE_OFS, 32'hc0);
      mode_is(3'h5);
      axi_wr(opmode_pkg::MODE_OFS, 32'he0);
      mode_is(3'h7);
      axi_wr(opmode_pkg::MODE_OFS, 32'ha0);
      mode_is(3'h7);
      // debug link only used outside peripheral mode
      axi_wr(opmode_pkg::DEBUG_OFS, 32'h2);
      axi_rd(opmode_pkg::DEBUG_OFS);
      chk("debug_state", 0, 32'(rd[1:0]));
      axi_wr(opmode_pkg::DEBUG_OFS, 32'h1);
      axi_wr(opmode_pkg::DEBUG_OFS, 32'h2);
      axi_rd(opmode_pkg::DEBUG_OFS);
      chk("debug_state", 3, 32'(rd[1:0]));
      chk("serial_debug_mode", 1, 32'(serial_debug_mode));
      $display("test normal writes done");
      do_reset(3'h1, 3'h0);
      axi_wr(opmode_pkg::MODE_OFS, 32'h40);
      mode_is(3'h1);
      axi_wr(opmode_pkg::MODE_OFS, 32'h60);
      mode_is(3'h3);
      axi_wr(opmode_pkg::MODE_OFS, 32'h00);
      mode_is(3'h0);
      do_reset(3'h2, 3'h0);
      axi_wr(opmode_pkg::MODE_OFS, 32'h60, opmode_pkg::RESP_SLVERR);
      mode_is(3'h2);
      axi_rd(8'h0c);
      chk("rresp", 32'(opmode_pkg::RESP_SLVERR), 32'(rs));
      chk("rdata", 0, rd);
      $display("test special writes done");
      stop_test();
   end
   initial begin
      repeat (20000) @(posedge aclk);
      bad_count++;
      stop_test();
   end
endmodule : tb
